/* File: twc_line_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface twc_line_if;
  logic scl_s;
  logic sda_s;
  modport src (output scl_s, output sda_s);
  modport dst (input scl_s, input sda_s);
endinterface : twc_line_if
`default_nettype wire

/* File: twc_pkg.sv */
package twc_pkg;
  // register offsets (byte addresses)
  localparam logic [11:0] OFF_BEGIN_RX    = 12'h000;
  localparam logic [11:0] OFF_BEGIN_TX    = 12'h008;
  localparam logic [11:0] OFF_END_XFER    = 12'h014;
  localparam logic [11:0] OFF_PAUSE       = 12'h01C;
  localparam logic [11:0] OFF_CONTINUE    = 12'h020;
  localparam logic [11:0] OFF_LINKS       = 12'h200;
  localparam logic [11:0] OFF_IRQ_SET     = 12'h304;
  localparam logic [11:0] OFF_IRQ_CLR     = 12'h308;
  localparam logic [11:0] OFF_FAULT_CAUSE = 12'h4C4;
  localparam logic [11:0] OFF_ENABLE      = 12'h500;
  localparam logic [11:0] OFF_PSEL_CLK    = 12'h508;
  localparam logic [11:0] OFF_PSEL_DATA   = 12'h50C;
  localparam logic [11:0] OFF_RX_BYTE     = 12'h518;
  localparam logic [11:0] OFF_TX_BYTE     = 12'h51C;
  localparam logic [11:0] OFF_RATE        = 12'h524;
  localparam logic [11:0] OFF_TARGET      = 12'h588;

  // event bit positions, shared by event, mask and interrupt logic
  localparam int unsigned EV_N       = 6;
  localparam int unsigned EV_STOPPED = 0;
  localparam int unsigned EV_RXRDY   = 1;
  localparam int unsigned EV_TXSENT  = 2;
  localparam int unsigned EV_FAULT   = 3;
  localparam int unsigned EV_BB      = 4;
  localparam int unsigned EV_PAUSED  = 5;
  localparam logic [11:0] EV_OFFS [0:EV_N-1] =
    '{12'h104, 12'h108, 12'h11C, 12'h124, 12'h138, 12'h148};

  // shortcut bits, fault cause bits and the enable bit
  localparam int unsigned LINK_PAUSE_BB = 0;
  localparam int unsigned LINK_END_BB   = 1;
  localparam int unsigned FC_ADDR_NACK  = 1;
  localparam int unsigned FC_DATA_NACK  = 2;
  localparam int unsigned ENABLE_BIT    = 0;

  // reset values
  localparam logic [31:0] RST_PSEL   = 32'hFFFF_FFFF;
  localparam logic [6:0]  RST_TARGET = 7'h00;

  // timing: bus_rate holds system clocks per quarter bit
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned BUS_HZ      = 100_000;
  localparam logic [7:0]  RST_QUARTER = 8'(CLK_HZ / (4 * BUS_HZ));

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_START = 5'b00010,
    ST_BIT   = 5'b00100,
    ST_HOLD  = 5'b01000,
    ST_STOP  = 5'b10000
  } twc_state_e;
endpackage : twc_pkg

/* File: twc_slave_model.sv */
`timescale 1ns/10ps
`default_nettype none
module twc_slave_model
#(
  parameter logic [7:0] DATA = 8'hA5
)
(
  // bus lines
  input  wire logic scl,
  input  wire logic sda,
  output var logic  sda_rel,
  // observation
  output var logic  last_nack,
  output var int    n_stop
);
  logic [7:0] sh = 8'h00;
  int         bc = 0;
  logic       rd_ph = 1'b0;
  logic       first = 1'b0;
  logic       busy  = 1'b0;
  initial
  begin
    sda_rel = 1'b1;
    last_nack = 1'b0;
    n_stop = 0;
  end
  always @(negedge sda)
    if (scl)
    begin
      bc = 0;
      first = 1'b1;
      rd_ph = 1'b0;
      busy = 1'b1;
    end
  // only a rise after a start counts; the unknown-to-high step at reset must not
  always @(posedge sda)
    if (scl && busy)
    begin
      n_stop++;
      busy = 1'b0;
    end
  always @(posedge scl)
  begin
    if (bc < 8)
      sh = {sh[6:0], sda};
    if (bc == 7 && first)
      rd_ph = sda;
    if (bc == 8 && rd_ph && !first)
    begin
      last_nack = sda;
      // a nack ends our turn, so free the line for stop or restart
      rd_ph = !sda;
    end
    if (bc == 8)
      first = 1'b0;
    bc = (bc == 8) ? 0 : bc + 1;
  end
  always @(negedge scl)
    if (bc == 8)
      sda_rel = rd_ph && !first;
    else
      sda_rel = !(rd_ph && !first) || DATA[7 - bc];
endmodule : twc_slave_model
`default_nettype wire

/* File: twc_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module twc_sync
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // raw pins
  input  wire logic scl_i,
  input  wire logic sda_i,
  // synchronised levels
  twc_line_if.src   line
);
  logic [1:0] raw;
  logic [1:0] meta_r;
  logic [1:0] sync_r;

  assign raw = {sda_i, scl_i};

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_sync
      // idle bus level is high, so reset to released
      always_ff @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
        begin
          meta_r[g] <= 1'b1;
          sync_r[g] <= 1'b1;
        end
        else
        begin
          meta_r[g] <= raw[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign line.scl_s = sync_r[0];
  assign line.sda_s = sync_r[1];
endmodule : twc_sync
`default_nettype wire

/* File: twc_tick.sv */
`timescale 1ns/10ps
`default_nettype none
module twc_tick
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // control
  input  wire logic       en,
  input  wire logic [7:0] div,
  // one-cycle quarter-bit pulse
  output logic            tick
);
  logic [7:0] cnt_r;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      cnt_r <= 8'h00;
    else if (!en || tick)
      cnt_r <= 8'h00;
    else
      cnt_r <= cnt_r + 8'h01;
  end

  // a divisor of zero behaves as one
  assign tick = en && (cnt_r + 8'h01 >= div);
endmodule : twc_tick
`default_nettype wire

/* File: twc_top.sv */
// Contract
// R1 - software keeps at most one shortcut into the end task enabled at a time.
// R2 - write and read phases chain in any order and number, each later phase opening with a repeated start.
// R3 - a receive start after a write phase gives a repeated start and a read with no stop between.
// R4 - to follow a read with a repeated start software triggers a start task instead of the end task.
// R5 - software triggers that start task before it reads the last received byte.
// R6 - a start task pending when the last byte is taken makes that byte NACKed before the repeated start.
// R7 - for lowest power software stops the controller and then disables it.
// R8 - after triggering the end task software waits for the stopped event before disabling.
// R9 - the stopped event rises once the stop requested by the end task has completed.
// R10 - receive start, transmit start and end tasks sit at 0x000, 0x008, 0x014 and fire on a 1 in bit 0.
// R11 - a byte-boundary event at 0x138 is raised before every byte sent or received.
// R12 - a shortcut register at 0x200 lets local events trigger local tasks directly.
// R13 - the end task puts a stop condition on the bus and ends the sequence.
// R14 - after a received byte the clock is held low and the acknowledge withheld until the byte is read.
// R15 - writing 0 to a task register does nothing and task registers read as zero.
`timescale 1ns/10ps
`default_nettype none
module twc_top
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // register port
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // interrupt
  output logic             irq,
  // two-wire pins, open drain
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n
);
  twc_line_if line ();

  twc_pkg::twc_state_e state_r;
  logic [1:0]  phase_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shreg_r;
  logic        rd_dir_r;
  logic        addr_ph_r;
  logic        ack_bit_r;
  logic        nack_r;
  logic        scl_oe_n_r;
  logic        sda_oe_n_r;
  logic [twc_pkg::EV_N-1:0] ev_hit_r;
  logic [twc_pkg::EV_N-1:0] ev_r;
  logic [twc_pkg::EV_N-1:0] mask_r;
  logic [2:0]  fc_hit_r;
  logic [2:0]  fault_cause_r;
  logic [1:0]  links_r;
  logic        enable_r;
  logic [31:0] psel_clk_r;
  logic [31:0] psel_data_r;
  logic [7:0]  rxd_r;
  logic        rxd_full_r;
  logic [7:0]  txd_r;
  logic        txd_full_r;
  logic [7:0]  rate_r;
  logic [6:0]  target_r;
  logic        pend_rx_r;
  logic        pend_tx_r;
  logic        pend_stop_r;
  logic        paused_r;
  logic [31:0] rdata_r;
  logic        irq_r;

  logic tick;
  logic go;
  logic step;
  logic rx_data;
  logic rx_wait;
  logic pend_start;
  logic pend_any;
  logic bit_val;
  logic t_rx, t_tx, t_end, t_pause, t_cont;
  logic sc_pause, sc_end;
  logic start_take, stop_done, idle_stop, rx_done, tx_take, rx_read;
  logic [twc_pkg::EV_N-1:0] ev_set;
  logic [twc_pkg::EV_N-1:0] ev_clr;
  logic [31:0] rdata_nxt;

  twc_sync u_sync
  (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .line    (line.src)
  );

  twc_tick u_tick
  (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .en      (enable_r),
    .div     (rate_r),
    .tick    (tick)
  );

  // task strobes fire only on a 1 in bit 0
  assign t_rx    = wr && addr == twc_pkg::OFF_BEGIN_RX && wdata[0];  // [R10] [R15]
  assign t_tx    = wr && addr == twc_pkg::OFF_BEGIN_TX && wdata[0];  // [R10] [R15]
  assign t_end   = wr && addr == twc_pkg::OFF_END_XFER && wdata[0];  // [R10] [R15]
  assign t_pause = wr && addr == twc_pkg::OFF_PAUSE && wdata[0];
  assign t_cont  = wr && addr == twc_pkg::OFF_CONTINUE && wdata[0];
  assign rx_read = rd && addr == twc_pkg::OFF_RX_BYTE;

  // shortcuts: byte boundary straight into pause or end
  assign sc_pause = ev_hit_r[twc_pkg::EV_BB] && links_r[twc_pkg::LINK_PAUSE_BB];  // [R12]
  assign sc_end   = ev_hit_r[twc_pkg::EV_BB] && links_r[twc_pkg::LINK_END_BB];    // [R12]

  assign rx_data    = rd_dir_r && !addr_ph_r;
  assign rx_wait    = rx_data && bit_cnt_r == 4'd8;
  assign pend_start = pend_rx_r || pend_tx_r;
  assign pend_any   = pend_start || pend_stop_r;
  // pause freezes the engine only at a bit boundary, with the clock low except at a first start from idle, where it is still released
  assign go   = tick && enable_r
                && !(paused_r && phase_r == 2'd0 && state_r != twc_pkg::ST_IDLE);
  assign step = phase_r != 2'd2 || line.scl_s;
  assign bit_val = (bit_cnt_r < 4'd8) ? (rx_data || shreg_r[7])
                                      : (!rx_data || ack_bit_r);

  assign start_take = go && state_r == twc_pkg::ST_START && phase_r == 2'd3;
  assign stop_done  = go && state_r == twc_pkg::ST_STOP && phase_r == 2'd3;
  assign idle_stop  = go && state_r == twc_pkg::ST_IDLE && pend_stop_r && !pend_start;
  assign rx_done    = go && state_r == twc_pkg::ST_BIT && phase_r == 2'd3 && rx_data
                      && bit_cnt_r == 4'd7;
  assign tx_take    = go && state_r == twc_pkg::ST_HOLD && !rx_wait && !pend_any
                      && !rd_dir_r && txd_full_r && !nack_r;

  // bus engine
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r    <= twc_pkg::ST_IDLE;
      phase_r    <= 2'd0;
      bit_cnt_r  <= 4'd0;
      shreg_r    <= 8'h00;
      rd_dir_r   <= 1'b0;
      addr_ph_r  <= 1'b0;
      ack_bit_r  <= 1'b0;
      nack_r     <= 1'b0;
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
      ev_hit_r   <= '0;
      fc_hit_r   <= 3'h0;
    end
    else
    begin
      ev_hit_r <= '0;
      fc_hit_r <= 3'h0;
      if (!enable_r)
      begin
        state_r    <= twc_pkg::ST_IDLE;
        phase_r    <= 2'd0;
        scl_oe_n_r <= 1'b1;
        sda_oe_n_r <= 1'b1;
      end
      else if (go)
      begin
        unique case (state_r)
          twc_pkg::ST_IDLE:
          begin
            if (pend_start)
              state_r <= twc_pkg::ST_START;
            else if (pend_stop_r)
              ev_hit_r[twc_pkg::EV_STOPPED] <= 1'b1;  // [R9]
          end
          twc_pkg::ST_START:
          begin
            // same shape for first and repeated start: data low while clock high
            if (step)
              phase_r <= phase_r + 2'd1;
            case (phase_r)
              2'd0: sda_oe_n_r <= 1'b1;
              2'd1: scl_oe_n_r <= 1'b1;
              2'd2: if (line.scl_s) sda_oe_n_r <= 1'b0;
              default:
              begin
                scl_oe_n_r <= 1'b0;
                rd_dir_r   <= pend_rx_r;                     // [R2] [R3]
                shreg_r    <= {target_r, pend_rx_r};
                addr_ph_r  <= 1'b1;
                bit_cnt_r  <= 4'd0;
                nack_r     <= 1'b0;
                ev_hit_r[twc_pkg::EV_BB] <= 1'b1;            // [R11]
                state_r    <= twc_pkg::ST_BIT;
              end
            endcase
          end
          twc_pkg::ST_BIT:
          begin
            if (step)
              phase_r <= phase_r + 2'd1;
            case (phase_r)
              2'd0: sda_oe_n_r <= bit_val;
              2'd1: scl_oe_n_r <= 1'b1;
              2'd2: ;
              default:
              begin
                scl_oe_n_r <= 1'b0;
                if (bit_cnt_r < 4'd8)
                begin
                  shreg_r   <= {shreg_r[6:0], line.sda_s};
                  bit_cnt_r <= bit_cnt_r + 4'd1;
                  if (rx_data && bit_cnt_r == 4'd7)
                  begin
                    ev_hit_r[twc_pkg::EV_RXRDY] <= 1'b1;
                    state_r <= twc_pkg::ST_HOLD;             // [R14]
                  end
                end
                else if (rx_data)
                begin
                  bit_cnt_r <= 4'd0;
                  if (ack_bit_r)
                    state_r <= twc_pkg::ST_HOLD;
                  else
                    ev_hit_r[twc_pkg::EV_BB] <= 1'b1;        // [R11]
                end
                else if (line.sda_s)
                begin
                  nack_r <= 1'b1;
                  ev_hit_r[twc_pkg::EV_FAULT] <= 1'b1;
                  fc_hit_r[twc_pkg::FC_ADDR_NACK] <= addr_ph_r;
                  fc_hit_r[twc_pkg::FC_DATA_NACK] <= !addr_ph_r;
                  state_r <= twc_pkg::ST_HOLD;
                end
                else if (addr_ph_r && rd_dir_r)
                begin
                  addr_ph_r <= 1'b0;
                  bit_cnt_r <= 4'd0;
                  ev_hit_r[twc_pkg::EV_BB] <= 1'b1;          // [R11]
                end
                else
                begin
                  ev_hit_r[twc_pkg::EV_TXSENT] <= !addr_ph_r;
                  addr_ph_r <= 1'b0;
                  state_r   <= twc_pkg::ST_HOLD;
                end
              end
            endcase
          end
          twc_pkg::ST_HOLD:
          begin
            // clock stays low here; the read byte is acked only once taken
            if (rx_wait)
            begin
              if (!rxd_full_r)
              begin
                ack_bit_r <= pend_any;                       // [R6] [R14]
                state_r   <= twc_pkg::ST_BIT;
              end
            end
            else if (pend_stop_r)
              state_r <= twc_pkg::ST_STOP;                   // [R13]
            else if (pend_start)
              state_r <= twc_pkg::ST_START;                  // [R2] [R3]
            else if (tx_take)
            begin
              shreg_r   <= txd_r;
              bit_cnt_r <= 4'd0;
              ev_hit_r[twc_pkg::EV_BB] <= 1'b1;              // [R11]
              state_r   <= twc_pkg::ST_BIT;
            end
          end
          twc_pkg::ST_STOP:
          begin
            if (step)
              phase_r <= phase_r + 2'd1;
            case (phase_r)
              2'd0: sda_oe_n_r <= 1'b0;
              2'd1: scl_oe_n_r <= 1'b1;
              2'd2: ;
              default:
              begin
                sda_oe_n_r <= 1'b1;                          // [R13]
                rd_dir_r   <= 1'b0;
                ev_hit_r[twc_pkg::EV_STOPPED] <= 1'b1;       // [R9]
                state_r    <= twc_pkg::ST_IDLE;
              end
            endcase
          end
        endcase
      end
    end
  end

  // pending tasks; a new trigger wins over a same-cycle consume
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pend_rx_r   <= 1'b0;
      pend_tx_r   <= 1'b0;
      pend_stop_r <= 1'b0;
      paused_r    <= 1'b0;
    end
    else
    begin
      if (start_take)
      begin
        pend_rx_r <= 1'b0;
        pend_tx_r <= 1'b0;
      end
      if (stop_done || idle_stop)
        pend_stop_r <= 1'b0;
      if (t_cont)
        paused_r <= 1'b0;
      if (t_rx)
        pend_rx_r <= 1'b1;                                   // [R10]
      if (t_tx)
        pend_tx_r <= 1'b1;                                   // [R10]
      if (t_end || sc_end)
        pend_stop_r <= 1'b1;                                 // [R13] [R12]
      if (t_pause || sc_pause)
        paused_r <= 1'b1;                                    // [R12]
    end
  end

  // receive and transmit holding bytes
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rxd_r      <= 8'h00;
      rxd_full_r <= 1'b0;
      txd_r      <= 8'h00;
      txd_full_r <= 1'b0;
    end
    else
    begin
      if (rx_read)
        rxd_full_r <= 1'b0;                                  // [R14]
      if (rx_done)
      begin
        rxd_r      <= {shreg_r[6:0], line.sda_s};
        rxd_full_r <= 1'b1;
      end
      if (tx_take)
        txd_full_r <= 1'b0;
      if (wr && addr == twc_pkg::OFF_TX_BYTE)
      begin
        txd_r      <= wdata[7:0];
        txd_full_r <= 1'b1;
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      links_r     <= 2'b00;
      enable_r    <= 1'b0;
      psel_clk_r  <= twc_pkg::RST_PSEL;
      psel_data_r <= twc_pkg::RST_PSEL;
      rate_r      <= twc_pkg::RST_QUARTER;
      target_r    <= twc_pkg::RST_TARGET;
      mask_r      <= '0;
    end
    else if (wr)
    begin
      case (addr)
        twc_pkg::OFF_LINKS:     links_r     <= wdata[1:0];     // [R12]
        twc_pkg::OFF_ENABLE:    enable_r    <= wdata[twc_pkg::ENABLE_BIT];
        twc_pkg::OFF_PSEL_CLK:  psel_clk_r  <= wdata;
        twc_pkg::OFF_PSEL_DATA: psel_data_r <= wdata;
        twc_pkg::OFF_RATE:      rate_r      <= wdata[7:0];
        twc_pkg::OFF_TARGET:    target_r    <= wdata[6:0];
        twc_pkg::OFF_IRQ_SET:   mask_r      <= mask_r | wdata[twc_pkg::EV_N-1:0];
        twc_pkg::OFF_IRQ_CLR:   mask_r      <= mask_r & ~wdata[twc_pkg::EV_N-1:0];
        default: ;
      endcase
    end
  end

  // sticky events, cleared by a 1 in bit 0 at their own offset
  genvar g;
  generate
    for (g = 0; g < twc_pkg::EV_N; g++)
    begin : g_ev
      assign ev_clr[g] = wr && addr == twc_pkg::EV_OFFS[g] && wdata[0];
    end
  endgenerate

  always_comb
  begin
    ev_set = ev_hit_r;
    ev_set[twc_pkg::EV_PAUSED] = (t_pause || sc_pause) && !paused_r;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ev_r          <= '0;
      fault_cause_r <= 3'h0;
      irq_r         <= 1'b0;
    end
    else
    begin
      // a set in the clearing cycle survives
      ev_r <= (ev_r & ~ev_clr) | ev_set;
      if (wr && addr == twc_pkg::OFF_FAULT_CAUSE)
        fault_cause_r <= (fault_cause_r & ~wdata[2:0]) | fc_hit_r;
      else
        fault_cause_r <= fault_cause_r | fc_hit_r;
      irq_r <= |(ev_r & mask_r);
    end
  end

  // read mux; tasks and unmapped offsets read zero
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    for (int i = 0; i < twc_pkg::EV_N; i++)
      if (addr == twc_pkg::EV_OFFS[i])
        rdata_nxt = {31'h0000_0000, ev_r[i]};
    case (addr)
      twc_pkg::OFF_LINKS:       rdata_nxt = {30'h0000_0000, links_r};
      twc_pkg::OFF_IRQ_SET,
      twc_pkg::OFF_IRQ_CLR:     rdata_nxt = {26'h000_0000, mask_r};
      twc_pkg::OFF_FAULT_CAUSE: rdata_nxt = {29'h0000_0000, fault_cause_r};
      twc_pkg::OFF_ENABLE:      rdata_nxt = {31'h0000_0000, enable_r};
      twc_pkg::OFF_PSEL_CLK:    rdata_nxt = psel_clk_r;
      twc_pkg::OFF_PSEL_DATA:   rdata_nxt = psel_data_r;
      twc_pkg::OFF_RX_BYTE:     rdata_nxt = {24'h00_0000, rxd_r};
      twc_pkg::OFF_TX_BYTE:     rdata_nxt = {24'h00_0000, txd_r};
      twc_pkg::OFF_RATE:        rdata_nxt = {24'h00_0000, rate_r};
      twc_pkg::OFF_TARGET:      rdata_nxt = {25'h000_0000, target_r};
      default: ;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rdata_r <= 32'h0000_0000;
    else if (rd)
      rdata_r <= rdata_nxt;                                  // [R15]
    else
      rdata_r <= 32'h0000_0000;
  end

  // open drain: drive value is always low
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  assign rdata    = rdata_r;
  assign irq      = irq_r;
  assign scl_oe_n = scl_oe_n_r;
  assign sda_oe_n = sda_oe_n_r;

  sequence s_stop_last;
    state_r == twc_pkg::ST_STOP && go && phase_r == 2'd3;
  endsequence

  sequence s_rx_taken;
    state_r == twc_pkg::ST_HOLD && go && rx_wait && !rxd_full_r;
  endsequence

  a_stopped_raised: assert property (@(posedge clk_sys) disable iff (!resetn) // [R9]
    s_stop_last |=> ##1 ev_r[twc_pkg::EV_STOPPED])
    else $error("stopped event missing after stop");
  a_stop_sda_rise: assert property (@(posedge clk_sys) disable iff (!resetn) // [R13]
    s_stop_last |=> sda_oe_n_r && scl_oe_n_r && state_r == twc_pkg::ST_IDLE)
    else $error("stop condition not completed");
  a_rx_clock_held: assert property (@(posedge clk_sys) disable iff (!resetn) // [R14]
    (state_r == twc_pkg::ST_HOLD && rx_wait && rxd_full_r && enable_r) |-> !scl_oe_n_r)
    else $error("clock released before byte read");
  a_nack_pending: assert property (@(posedge clk_sys) disable iff (!resetn) // [R6]
    (s_rx_taken and pend_any) |=> ack_bit_r && state_r == twc_pkg::ST_BIT)
    else $error("last byte not nacked");
  a_restart_path: assert property (@(posedge clk_sys) disable iff (!resetn) // [R2]
    (state_r == twc_pkg::ST_HOLD && go && !rx_wait && !pend_stop_r && pend_start)
    |=> state_r == twc_pkg::ST_START)
    else $error("repeated start not taken");
  a_bb_before_byte: assert property (@(posedge clk_sys) disable iff (!resetn) // [R11]
    ($rose(state_r == twc_pkg::ST_BIT) && bit_cnt_r == 4'd0) |=> ev_r[twc_pkg::EV_BB])
    else $error("byte boundary event missing");
  a_task_read_zero: assert property (@(posedge clk_sys) disable iff (!resetn) // [R15]
    (rd && (addr == twc_pkg::OFF_BEGIN_RX || addr == twc_pkg::OFF_END_XFER))
    |=> rdata_r == 32'h0000_0000)
    else $error("task register read not zero");
  a_zero_write_noop: assert property (@(posedge clk_sys) disable iff (!resetn) // [R15]
    (wr && addr == twc_pkg::OFF_BEGIN_TX && !wdata[0] && !pend_tx_r) |=> !pend_tx_r)
    else $error("zero write triggered task");
  a_end_task_taken: assert property (@(posedge clk_sys) disable iff (!resetn) // [R10]
    (t_end && !stop_done && !idle_stop) |=> pend_stop_r)
    else $error("end task lost");
  a_link_end: assert property (@(posedge clk_sys) disable iff (!resetn) // [R12]
    (sc_end && !stop_done && !idle_stop) |=> pend_stop_r)
    else $error("shortcut to end not applied");
  a_irq_level: assert property (@(posedge clk_sys) disable iff (!resetn) // [R9]
    (|(ev_r & mask_r)) [*2] |-> irq_r)
    else $error("interrupt not raised");
endmodule : twc_top
`default_nettype wire

/* File: twc_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module twc_top_tb;
  logic clk_sys, resetn, wr, rd, irq, scl_o, scl_oe_n, sda_o, sda_oe_n, sda_rel, last_nack;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  int          n_stop, error_cnt = 0, checks_done = 0, cyc = 0;
  // pulled-up lines
  wire         scl = scl_oe_n;
  wire         sda = sda_oe_n & sda_rel;
  twc_top twc_top_inst (.clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .scl_i(scl), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
  twc_slave_model twc_slave_model_inst (.scl(scl), .sda(sda), .sda_rel(sda_rel),
    .last_nack(last_nack), .n_stop(n_stop));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr_reg
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk_sys);
  endtask : rd_reg
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd_reg(a, v);
    chk(v, exp);
  endtask : rchk
  // poll an event, then clear it
  task automatic wait_ev(input int i);
    logic [31:0] v = 0;
    for (int n = 0; n < 400 && v[0] !== 1'b1; n++)
      rd_reg(twc_pkg::EV_OFFS[i], v);
    chk(v, 1);
    wr_reg(twc_pkg::EV_OFFS[i], 1);
  endtask : wait_ev
  task automatic tally_and_finish;
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial
  begin
    {resetn, wr, rd, addr, wdata} = '0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rchk(twc_pkg::OFF_RATE, 32'h19);
    rchk(twc_pkg::OFF_PSEL_CLK, twc_pkg::RST_PSEL);
    rchk(12'h008, 0);
    rchk(12'hFFC, 0);
    wr_reg(twc_pkg::OFF_RATE, 2);
    wr_reg(twc_pkg::OFF_TARGET, 8'h50);
    wr_reg(twc_pkg::OFF_TX_BYTE, 8'h3C);
    wr_reg(twc_pkg::OFF_ENABLE, 1);
    wr_reg(12'h008, 0);
    repeat (20) @(posedge clk_sys);
    chk(sda_oe_n, 1);
    wr_reg(12'h008, 1);
    wait_ev(twc_pkg::EV_BB);
    wait_ev(twc_pkg::EV_TXSENT);
    wr_reg(12'h000, 1);
    wait_ev(twc_pkg::EV_RXRDY);
    chk(scl_oe_n, 0);
    chk(n_stop, 0);
    wr_reg(twc_pkg::OFF_TX_BYTE, 8'h5A);
    wr_reg(12'h008, 1);
    rchk(twc_pkg::OFF_RX_BYTE, 8'hA5);
    wait_ev(twc_pkg::EV_TXSENT);
    chk(last_nack, 1);
    chk(n_stop, 0);
    wr_reg(12'h014, 1);
    wait_ev(twc_pkg::EV_STOPPED);
    chk({scl, sda, scl_o, sda_o, 28'(n_stop)}, {4'b1100, 28'd1});
    wr_reg(twc_pkg::OFF_LINKS, 2);
    wr_reg(12'h000, 1);
    wait_ev(twc_pkg::EV_RXRDY);
    // the stop from the shortcut still waits until the byte is taken
    rchk(twc_pkg::OFF_RX_BYTE, 8'hA5);
    wait_ev(twc_pkg::EV_STOPPED);
    chk(n_stop, 2);
    wr_reg(twc_pkg::OFF_LINKS, 0);
    wr_reg(twc_pkg::OFF_IRQ_SET, 1);
    wr_reg(12'h014, 1);
    for (int n = 0; n < 100 && irq !== 1'b1; n++)
      @(posedge clk_sys);
    #1 chk(irq, 1);
    wr_reg(twc_pkg::OFF_IRQ_CLR, 1);
    #1 chk(irq, 0);
    wr_reg(twc_pkg::OFF_IRQ_SET, 1);
    #1 chk(irq, 1);
    wr_reg(twc_pkg::EV_OFFS[0], 1);
    #1 chk(irq, 0);
    wr_reg(twc_pkg::OFF_ENABLE, 0);
    rchk(twc_pkg::OFF_ENABLE, 0);
    tally_and_finish();
  end
endmodule : twc_top_tb
`default_nettype wire
